// ==== hw/debug_wire_regs.vh ====
// Constants for the single-wire debug command unit
`ifndef DEBUG_WIRE_REGS_VH
`define DEBUG_WIRE_REGS_VH
`define DW_WB_CTRL      4'h0
`define DW_WB_MATCH     4'h4
`define DW_WB_STATE     4'h8
`define DW_BIT_DMEN     7
`define DW_BIT_HALTED   6
`define DW_BIT_BPEN     5
`define DW_BIT_FRC      4
`define DW_BIT_ACKEN    3
`define DW_RST_DMEN     1'h0
`define DW_RST_BPEN     1'h0
`define DW_RST_FRC      1'h0
`define DW_RST_ACKEN    1'h0
`define DW_RST_MATCH    16'h0000
`define DW_BIT_SAMPLE   10'h00a
`define DW_SPEEDUP      10'h007
`define DW_ZERO_LOW     10'h00d
`define DW_TIMEOUT      10'h200
`define DW_SYNC_DETECT  8'h80
`define DW_SYNC_WAIT    8'h10
`define DW_SYNC_LOW     8'h80
`define DW_DELAY        5'h10
`define DW_SHORT_WAIT   5'h02
`define DW_CMD_ACK_ON   8'hd5
`define DW_CMD_ACK_OFF  8'hd6
`define DW_CMD_HALT     8'h90
`define DW_CMD_STATE    8'he4
`define DW_CMD_CONTROL  8'hc4
`define DW_CMD_RD       8'he0
`define DW_CMD_RD_SS    8'he1
`define DW_CMD_RD_LAST  8'he8
`define DW_CMD_WR       8'hc0
`define DW_CMD_WR_SS    8'hc1
`define DW_CMD_MATCH_RD 8'he2
`define DW_CMD_MATCH_WR 8'hc2
`define DW_CMD_RESUME   8'h08
`define DW_CMD_STEP     8'h10
`define DW_CMD_RESUME_T 8'h18
`define DW_CMD_ACC_RD   8'h68
`define DW_CMD_FLG_RD   8'h69
`define DW_CMD_PC_RD    8'h6b
`define DW_CMD_HX_RD    8'h6c
`define DW_CMD_SP_RD    8'h6f
`define DW_CMD_NEXT_RD  8'h70
`define DW_CMD_NEXT_RDS 8'h71
`define DW_CMD_ACC_WR   8'h48
`define DW_CMD_FLG_WR   8'h49
`define DW_CMD_PC_WR    8'h4b
`define DW_CMD_HX_WR    8'h4c
`define DW_CMD_SP_WR    8'h4f
`define DW_CMD_NEXT_WR  8'h50
`define DW_CMD_NEXT_WRS 8'h51
`endif

// ==== hw/debug_wire_phy.v ====
// Bit-level front end of the debug wire: sampling, bit timing, sync
`timescale 1ns/1ps
`include "debug_wire_regs.vh"
module debug_wire_phy (
    input  wire core_clk,
    input  wire srst,
    input  wire pin_level,
    output reg  pin_drive,
    output reg  pin_oe_n,
    input  wire tx_en,
    input  wire tx_bit,
    output reg  sample_stb,
    output reg  rx_bit,
    output reg  timeout_stb,
    output reg  sync_stb
);
    localparam S_IDLE  = 2'h0;
    localparam S_HIGH  = 2'h1;
    localparam S_WAIT  = 2'h2;
    localparam S_DRIVE = 2'h3;

    reg       q1_r, q2_r, q3_r, lvl_r, run_r, txe_r, txb_r;
    reg [9:0] cnt_r;
    reg [7:0] low_r;
    reg [7:0] scnt_r;
    reg [1:0] sst_r;

    // Level counts only once the last two stages agree
    wire agree = (q2_r == q3_r);
    wire fall  = agree & ~q3_r & lvl_r & (sst_r == S_IDLE);

    always @(posedge core_clk) begin
        if (srst) begin
            q1_r <= 1'h1; q2_r <= 1'h1; q3_r <= 1'h1; lvl_r <= 1'h1;
            run_r <= 1'h0; txe_r <= 1'h0; txb_r <= 1'h0;
            cnt_r <= `DW_TIMEOUT; low_r <= 8'h00; scnt_r <= 8'h00; sst_r <= S_IDLE;
            pin_drive <= 1'h1; pin_oe_n <= 1'h1;
            sample_stb <= 1'h0; rx_bit <= 1'h0; timeout_stb <= 1'h0; sync_stb <= 1'h0;
        end else begin
            q1_r <= pin_level;
            q2_r <= q1_r;
            q3_r <= q2_r;
            if (agree)
                lvl_r <= q3_r;
            sample_stb  <= 1'h0;
            timeout_stb <= 1'h0;
            sync_stb    <= 1'h0;
            if (fall) begin
                cnt_r <= 10'h000;
                run_r <= 1'h1;
                txe_r <= tx_en;
                txb_r <= tx_bit;
            end else if (cnt_r != `DW_TIMEOUT) begin
                cnt_r <= cnt_r + 10'h001;
                if (cnt_r == `DW_TIMEOUT - 10'h001)
                    timeout_stb <= 1'h1;
                if (cnt_r == `DW_ZERO_LOW)
                    run_r <= 1'h0;
                if (run_r & (cnt_r == `DW_BIT_SAMPLE)) begin
                    sample_stb <= 1'h1;
                    if (~txe_r)
                        rx_bit <= lvl_r;
                end
            end
            // Long low from the host is a sync request, though its start is still sampled as a bit
            if (sst_r == S_IDLE && !lvl_r && low_r != 8'hff)
                low_r <= low_r + 8'h01;
            else if (lvl_r)
                low_r <= 8'h00;
            case (sst_r)
                S_IDLE: if (!lvl_r && low_r == `DW_SYNC_DETECT - 8'h01) begin
                    sst_r <= S_HIGH;
                    sync_stb <= 1'h1;
                    run_r <= 1'h0;
                end
                S_HIGH: if (lvl_r) begin
                    sst_r  <= S_WAIT;
                    scnt_r <= 8'h00;
                end
                S_WAIT: begin
                    scnt_r <= scnt_r + 8'h01;
                    if (scnt_r == `DW_SYNC_WAIT - 8'h01) begin
                        sst_r  <= S_DRIVE;
                        scnt_r <= 8'h00;
                    end
                end
                S_DRIVE: begin
                    scnt_r <= scnt_r + 8'h01;
                    if (scnt_r == `DW_SYNC_LOW)
                        sst_r <= S_IDLE;
                end
                default: sst_r <= S_IDLE;
            endcase
            if (sst_r == S_DRIVE) begin
                pin_oe_n  <= 1'h0;
                pin_drive <= (scnt_r == `DW_SYNC_LOW);
            end else if (run_r & txe_r & ~txb_r & (cnt_r < `DW_ZERO_LOW)) begin
                pin_oe_n  <= 1'h0;
                pin_drive <= 1'h0;
            end else if (run_r & txe_r & (cnt_r == (txb_r ? `DW_SPEEDUP : `DW_ZERO_LOW))) begin
                pin_oe_n  <= 1'h0;
                pin_drive <= 1'h1;
            end else begin
                pin_oe_n  <= 1'h1;
                pin_drive <= 1'h1;
            end
        end
    end
endmodule // debug_wire_phy

// ==== hw/debug_wire_cmd_unit.v ====
// Command layer, control registers and breakpoint of the debug wire
//
// Function
// - Command starts with 8-bit code, MSB first
// - Delay slot lasts 16 debug clock cycles
// - Address 16 bits, bytes 8, pairs 16
// - Status phase reads, control phase writes register
// - D5/D6 turn acknowledge on/off
// - Code 90 halts only when enabled
// - E4 returns status, C4 writes control
// - E0/E1 read memory, E1 adds status
// - E8 re-reads last address with status
// - C0/C1 write memory, C1 adds status
// - E2/C2 read/load breakpoint match, no delay
// - 08/18 resume, 10 single-steps
// - 68..6F read CPU registers
// - 48..4F load CPU registers
// - 70/71 increment index, read memory
// - 50/51 increment index, write memory
// - Sync answer: wait, 16, low 128, pulse
// - Forced breakpoint halts on any matching access
// - Tagged breakpoint marks fetched opcode only
// - Breakpoint enable resets to zero, gates all
// - Force/tag select: one forced, zero tagged
// - Bit time begins at host falling edge
// - 512 idle cycles abandon the command
// - Register and run commands need halted CPU
//
// Register access over Wishbone and the register offsets were chosen for this implementation.
`timescale 1ns/1ps
`include "debug_wire_regs.vh"
module debug_wire_cmd_unit (
    input  wire        core_clk,
    input  wire        srst,
    input  wire        debug_wire_pin_level,
    output wire        debug_wire_pin_drive,
    output wire        debug_wire_pin_oe_n,
    input  wire [3:0]  wb_adr,
    input  wire [31:0] wb_dat_w,
    output reg  [31:0] wb_dat_r,
    input  wire [3:0]  wb_sel,
    input  wire        wb_we,
    input  wire        wb_cyc,
    input  wire        wb_stb,
    output reg         wb_ack,
    input  wire        cpu_halted,
    input  wire [7:0]  cpu_acc,
    input  wire [7:0]  cpu_flags,
    input  wire [15:0] cpu_pc,
    input  wire [15:0] cpu_hx,
    input  wire [15:0] cpu_sp,
    output reg  [4:0]  cpu_reg_wr,
    output reg  [15:0] cpu_reg_wdata,
    output reg         halt_req,
    output reg         resume_req,
    output reg         step_req,
    output reg         mem_req,
    output reg         mem_we,
    output reg  [15:0] mem_addr,
    output reg  [7:0]  mem_wdata,
    input  wire [7:0]  mem_rdata,
    input  wire [15:0] cpu_addr,
    input  wire        cpu_access,
    input  wire        cpu_fetch,
    output reg         force_bkpt,
    output reg         tag_bkpt
);
    localparam ST_CMD  = 3'h0;
    localparam ST_RX   = 3'h1;
    localparam ST_EXEC = 3'h2;
    localparam ST_WAIT = 3'h3;
    localparam ST_TX   = 3'h4;

    // Index pair strobe, shared by the increment codes
    localparam WR_HX  = 5'h08;

    reg  [2:0]  st_r;
    reg  [4:0]  nb_r;
    reg  [4:0]  wcnt_r;
    reg  [23:0] sh_r;
    reg  [23:0] tx_r;
    reg  [7:0]  cmd_r;
    reg  [7:0]  info_r;
    reg  [15:0] last_addr_r;
    reg  [15:0] match_r;
    reg         dm_en_r;
    reg         bp_en_r;
    reg         frc_r;
    reg         acken_r;
    reg  [7:0]  state_byte;
    reg  [15:0] payload;
    wire        smp;
    wire        rxb;
    wire        tmo;
    wire        syn;
    wire [7:0]  info_nxt;
    wire [15:0] hx_inc = cpu_hx + 16'h0001;
    wire        wb_hit = wb_cyc & wb_stb & ~wb_ack;

    // Shape of each code: [7] known, [6] halted only, [5] delay,
    // [4:3] bytes in, [2:1] bytes out, [0] status byte leads output
    function [7:0] cmd_shape;
        input [7:0] code;
        begin
            case (code)
                `DW_CMD_ACK_ON, `DW_CMD_ACK_OFF, `DW_CMD_HALT: cmd_shape = 8'ha0;
                `DW_CMD_STATE:    cmd_shape = 8'h83;
                `DW_CMD_CONTROL:  cmd_shape = 8'h88;
                `DW_CMD_RD:       cmd_shape = 8'hb2;
                `DW_CMD_RD_SS:    cmd_shape = 8'hb5;
                `DW_CMD_RD_LAST:  cmd_shape = 8'h85;
                `DW_CMD_WR:       cmd_shape = 8'hb8;
                `DW_CMD_WR_SS:    cmd_shape = 8'hbb;
                `DW_CMD_MATCH_RD: cmd_shape = 8'h84;
                `DW_CMD_MATCH_WR: cmd_shape = 8'h90;
                `DW_CMD_RESUME, `DW_CMD_STEP, `DW_CMD_RESUME_T: cmd_shape = 8'he0;
                `DW_CMD_ACC_RD, `DW_CMD_FLG_RD, `DW_CMD_NEXT_RD: cmd_shape = 8'he2;
                `DW_CMD_PC_RD, `DW_CMD_HX_RD, `DW_CMD_SP_RD: cmd_shape = 8'he4;
                `DW_CMD_NEXT_RDS: cmd_shape = 8'he5;
                `DW_CMD_ACC_WR, `DW_CMD_FLG_WR, `DW_CMD_NEXT_WR: cmd_shape = 8'he8;
                `DW_CMD_PC_WR, `DW_CMD_HX_WR, `DW_CMD_SP_WR: cmd_shape = 8'hf0;
                `DW_CMD_NEXT_WRS: cmd_shape = 8'heb;
                default:          cmd_shape = 8'h00;
            endcase
        end
    endfunction

    assign info_nxt = cmd_shape({sh_r[6:0], rxb});

    debug_wire_phy u_phy (
        .core_clk    (core_clk),
        .srst        (srst),
        .pin_level   (debug_wire_pin_level),
        .pin_drive   (debug_wire_pin_drive),
        .pin_oe_n    (debug_wire_pin_oe_n),
        .tx_en       (st_r == ST_TX),
        .tx_bit      (tx_r[23]),
        .sample_stb  (smp),
        .rx_bit      (rxb),
        .timeout_stb (tmo),
        .sync_stb    (syn)
    );

    // Status byte, also the control byte layout
    always @* begin
        state_byte                 = 8'h00;
        state_byte[`DW_BIT_DMEN]   = dm_en_r;
        state_byte[`DW_BIT_HALTED] = cpu_halted;
        state_byte[`DW_BIT_BPEN]   = bp_en_r;
        state_byte[`DW_BIT_FRC]    = frc_r;
        state_byte[`DW_BIT_ACKEN]  = acken_r;
    end

    // Payload, high aligned
    always @* begin
        case (cmd_r)
            `DW_CMD_ACC_RD:   payload = {cpu_acc, 8'h00};
            `DW_CMD_FLG_RD:   payload = {cpu_flags, 8'h00};
            `DW_CMD_PC_RD:    payload = cpu_pc;
            `DW_CMD_HX_RD:    payload = cpu_hx;
            `DW_CMD_SP_RD:    payload = cpu_sp;
            `DW_CMD_MATCH_RD: payload = match_r;
            default:          payload = {mem_rdata, 8'h00};
        endcase
    end

    always @(posedge core_clk) begin
        if (srst) begin
            st_r <= ST_CMD;
            nb_r <= 5'h08;
            wcnt_r <= 5'h00;
            sh_r <= 24'h000000;
            tx_r <= 24'h000000;
            cmd_r <= 8'h00;
            info_r <= 8'h00;
            last_addr_r <= 16'h0000;
            match_r <= `DW_RST_MATCH;
            dm_en_r <= `DW_RST_DMEN;
            bp_en_r <= `DW_RST_BPEN;
            frc_r <= `DW_RST_FRC;
            acken_r <= `DW_RST_ACKEN;
            cpu_reg_wr <= 5'h00;
            cpu_reg_wdata <= 16'h0000;
            halt_req <= 1'h0;
            resume_req <= 1'h0;
            step_req <= 1'h0;
            mem_req <= 1'h0;
            mem_we <= 1'h0;
            mem_addr <= 16'h0000;
            mem_wdata <= 8'h00;
            wb_ack <= 1'h0;
            wb_dat_r <= 32'h00000000;
        end else begin
            cpu_reg_wr <= 5'h00;
            halt_req <= 1'h0;
            resume_req <= 1'h0;
            step_req <= 1'h0;
            mem_req <= 1'h0;
            wb_ack <= wb_hit;
            // Bus writes first so a serial write in the same cycle wins
            if (wb_hit & wb_we) begin
                if (wb_adr == `DW_WB_CTRL && wb_sel[0]) begin
                    dm_en_r <= wb_dat_w[`DW_BIT_DMEN];
                    bp_en_r <= wb_dat_w[`DW_BIT_BPEN];
                    frc_r   <= wb_dat_w[`DW_BIT_FRC];
                end
                if (wb_adr == `DW_WB_MATCH) begin
                    if (wb_sel[0])
                        match_r[7:0] <= wb_dat_w[7:0];
                    if (wb_sel[1])
                        match_r[15:8] <= wb_dat_w[15:8];
                end
            end
            if (wb_hit) begin
                case (wb_adr)
                    `DW_WB_CTRL:  wb_dat_r <= {24'h000000, state_byte};
                    `DW_WB_MATCH: wb_dat_r <= {16'h0000, match_r};
                    `DW_WB_STATE: wb_dat_r <= {23'h000000, st_r != ST_CMD, cmd_r};
                    default:      wb_dat_r <= 32'h00000000;
                endcase
            end
            case (st_r)
                ST_CMD: if (smp) begin
                    sh_r <= {sh_r[22:0], rxb};
                    if (nb_r == 5'h01) begin
                        nb_r <= 5'h08;
                        // Unknown codes, or halted-only codes while running, drop
                        if (info_nxt[7] && (!info_nxt[6] || cpu_halted)) begin
                            cmd_r  <= {sh_r[6:0], rxb};
                            info_r <= info_nxt;
                            if (info_nxt[4:3] != 2'h0) begin
                                st_r <= ST_RX;
                                nb_r <= {info_nxt[4:3], 3'h0};
                            end else begin
                                st_r <= ST_EXEC;
                            end
                        end
                    end else begin
                        nb_r <= nb_r - 5'h01;
                    end
                end
                ST_RX: if (smp) begin
                    sh_r <= {sh_r[22:0], rxb};
                    if (nb_r == 5'h01)
                        st_r <= ST_EXEC;
                    else
                        nb_r <= nb_r - 5'h01;
                end
                ST_EXEC: begin
                    // Side effects only here, after every input bit arrived
                    wcnt_r <= info_r[5] ? `DW_DELAY - 5'h01 : `DW_SHORT_WAIT - 5'h01;
                    st_r <= ST_WAIT;
                    case (cmd_r)
                        `DW_CMD_ACK_ON:  acken_r <= 1'h1;
                        `DW_CMD_ACK_OFF: acken_r <= 1'h0;
                        `DW_CMD_HALT:    halt_req <= dm_en_r;
                        `DW_CMD_CONTROL: begin
                            dm_en_r <= sh_r[`DW_BIT_DMEN];
                            bp_en_r <= sh_r[`DW_BIT_BPEN];
                            frc_r   <= sh_r[`DW_BIT_FRC];
                        end
                        `DW_CMD_MATCH_WR: match_r <= sh_r[15:0];
                        `DW_CMD_RD, `DW_CMD_RD_SS: begin
                            mem_req <= 1'h1;
                            mem_we <= 1'h0;
                            mem_addr <= sh_r[15:0];
                            last_addr_r <= sh_r[15:0];
                        end
                        `DW_CMD_RD_LAST: begin
                            mem_req <= 1'h1;
                            mem_we <= 1'h0;
                            mem_addr <= last_addr_r;
                        end
                        `DW_CMD_WR, `DW_CMD_WR_SS: begin
                            mem_req <= 1'h1;
                            mem_we <= 1'h1;
                            mem_addr <= sh_r[23:8];
                            mem_wdata <= sh_r[7:0];
                        end
                        `DW_CMD_RESUME, `DW_CMD_RESUME_T: resume_req <= 1'h1;
                        `DW_CMD_STEP: step_req <= 1'h1;
                        `DW_CMD_ACC_WR, `DW_CMD_FLG_WR, `DW_CMD_PC_WR, `DW_CMD_HX_WR, `DW_CMD_SP_WR: begin
                            // Strobe {sp,hx,pc,flags,acc} from the low code bits
                            cpu_reg_wr <= {cmd_r[2:0] == 3'h7, cmd_r[2:0] == 3'h4, cmd_r[2:0] == 3'h3,
                                           cmd_r[2:0] == 3'h1, cmd_r[2:0] == 3'h0};
                            cpu_reg_wdata <= info_r[4] ? sh_r[15:0] : {8'h00, sh_r[7:0]};
                        end
                        `DW_CMD_NEXT_RD, `DW_CMD_NEXT_RDS: begin
                            cpu_reg_wr <= WR_HX;
                            cpu_reg_wdata <= hx_inc;
                            mem_req <= 1'h1;
                            mem_we <= 1'h0;
                            mem_addr <= hx_inc;
                            last_addr_r <= hx_inc;
                        end
                        `DW_CMD_NEXT_WR, `DW_CMD_NEXT_WRS: begin
                            cpu_reg_wr <= WR_HX;
                            cpu_reg_wdata <= hx_inc;
                            mem_req <= 1'h1;
                            mem_we <= 1'h1;
                            mem_addr <= hx_inc;
                            mem_wdata <= sh_r[7:0];
                        end
                        default: st_r <= ST_WAIT;
                    endcase
                end
                ST_WAIT: if (wcnt_r == 5'h00) begin
                    if (info_r[2:1] == 2'h0) begin
                        st_r <= ST_CMD;
                        nb_r <= 5'h08;
                    end else begin
                        // Status byte leads when the code asks for it
                        tx_r <= info_r[0] ? {state_byte, payload} : {payload, 8'h00};
                        nb_r <= {info_r[2:1], 3'h0};
                        st_r <= ST_TX;
                    end
                end else begin
                    wcnt_r <= wcnt_r - 5'h01;
                end
                ST_TX: if (smp) begin
                    tx_r <= {tx_r[22:0], 1'h0};
                    if (nb_r == 5'h01) begin
                        st_r <= ST_CMD;
                        nb_r <= 5'h08;
                    end else begin
                        nb_r <= nb_r - 5'h01;
                    end
                end
                default: st_r <= ST_CMD;
            endcase
            // Abandon; side effects only fire in ST_EXEC
            if (tmo | syn) begin
                st_r <= ST_CMD;
                nb_r <= 5'h08;
            end
        end
    end

    // Match breakpoint; the CPU does the halt entry
    always @(posedge core_clk) begin
        if (srst) begin
            force_bkpt <= 1'h0;
            tag_bkpt <= 1'h0;
        end else begin
            force_bkpt <= bp_en_r & frc_r & cpu_access & (cpu_addr == match_r);
            tag_bkpt <= bp_en_r & ~frc_r & cpu_fetch & (cpu_addr == match_r);
        end
    end
endmodule // debug_wire_cmd_unit

// ==== dv/debug_wire_cmd_unit_props.sv ====
// Assertion checker for the debug wire command unit
`timescale 1ns/1ps
module debug_wire_cmd_unit_props (
    input wire       core_clk,
    input wire       srst,
    input wire       debug_wire_pin_drive,
    input wire       debug_wire_pin_oe_n,
    input wire       cpu_halted,
    input wire       cpu_access,
    input wire       cpu_fetch,
    input wire [4:0] cpu_reg_wr,
    input wire       resume_req,
    input wire       step_req,
    input wire       force_bkpt,
    input wire       tag_bkpt
);
    default clocking @(posedge core_clk); endclocking
    default disable iff (srst);
    wire       low_w = !debug_wire_pin_oe_n && !debug_wire_pin_drive;
    reg  [7:0] low_r;
    // Length of each driven-low run, zero between runs
    always @(posedge core_clk) begin
        if (srst || !low_w) low_r <= 8'h00;
        else low_r <= low_r + 8'h01;
    end
    force_cause_a: assert property (force_bkpt |-> $past(cpu_access)) else $error("force without access");
    tag_cause_a: assert property (tag_bkpt |-> $past(cpu_fetch)) else $error("tag without fetch");
    kind_excl_a: assert property (!(force_bkpt && tag_bkpt)) else $error("both breakpoint kinds");
    low_width_a: assert property (!low_w && low_r != 8'h00 |-> low_r == 8'h0d || low_r == 8'h80)
        else $error("low drive width wrong");
    speedup_a: assert property (!debug_wire_pin_oe_n && debug_wire_pin_drive |=> debug_wire_pin_oe_n)
        else $error("speedup pulse too long");
    run_halt_a: assert property (resume_req || step_req |-> $past(cpu_halted)) else $error("run while running");
    regwr_halt_a: assert property (cpu_reg_wr != 5'h00 |-> $past(cpu_halted)) else $error("reg write running");
    regwr_hot_a: assert property ($onehot0(cpu_reg_wr)) else $error("reg strobe not one-hot");
    bkpt_rst_a: assert property ($past(srst) |-> !force_bkpt && !tag_bkpt) else $error("breakpoint after reset");
    cover property (force_bkpt);
    cover property (tag_bkpt);
    cover property (low_r == 8'h80);
    cover property (cpu_reg_wr != 5'h00);
endmodule // debug_wire_cmd_unit_props
bind debug_wire_cmd_unit debug_wire_cmd_unit_props i_props (.*);

// ==== dv/debug_pod_model.sv ====
// Host-side debug pod model on the debug wire
`timescale 1ns/1ps
module debug_pod_model (
    input  wire core_clk,
    input  wire pin_drive,
    input  wire pin_oe_n,
    output wire pin_level
);
    reg hd = 1'b0;
    reg hv = 1'b1;
    // Pull-up holds the wire high when nobody drives
    assign pin_level = !pin_oe_n ? pin_drive : (hd ? hv : 1'b1);
    task automatic bitx(input logic b, output logic r);
        @(posedge core_clk);
        hd <= 1'b1; // Host fall opens every bit
        hv <= 1'b0;
        for (int i = 1; i < 22; i++) begin
            @(posedge core_clk);
            if (i == (b ? 5 : 15)) hd <= 1'b0;
            if (i == 12) r = pin_level;
        end
    endtask
    task automatic cmd(input [7:0] c, input int ni, input [23:0] di, input int dl, input int no, output logic [15:0] q);
        logic r;
        q = 16'h0000;
        for (int i = 7; i >= 0; i--) bitx(c[i], r);
        for (int i = ni - 1; i >= 0; i--) bitx(di[i], r);
        repeat (dl) @(posedge core_clk);
        for (int i = 0; i < no; i++) begin
            bitx(1'b1, r);
            q = {q[14:0], r};
        end
    endtask
    task automatic sync(output int lo);
        @(posedge core_clk);
        hd <= 1'b1; // Well past the detect threshold
        hv <= 1'b0;
        repeat (140) @(posedge core_clk);
        hv <= 1'b1;
        @(posedge core_clk);
        hd <= 1'b0;
        lo = 0;
        for (int i = 0; i < 400 && (lo == 0 || !pin_level); i++) begin
            @(posedge core_clk);
            if (!pin_level) lo++; // Low time sets the bit rate
        end
    endtask
endmodule // debug_pod_model

// ==== dv/debug_wire_cmd_unit_tb_top.sv ====
// Self-checking bench for the debug wire command unit
`timescale 1ns/1ps
module debug_wire_cmd_unit_tb_top;
    logic        core_clk = 1'b0, srst = 1'b1, wb_we = 1'b0, wb_cyc = 1'b0, wb_stb = 1'b0, b1;
    logic        cpu_halted = 1'b0, cpu_access = 1'b0, cpu_fetch = 1'b0;
    logic [3:0]  wb_adr = 4'h0, wb_sel = 4'h0;
    logic [4:0]  wr_seen = 5'h00;
    logic [31:0] wb_dat_w = 32'h0, r;
    logic [15:0] cpu_addr = 16'h0, cpu_hx = 16'h0200, q;
    wire         pin_level, pin_drive, pin_oe_n, wb_ack, halt_req, resume_req, step_req, mem_req, mem_we;
    wire         force_bkpt, tag_bkpt;
    wire  [31:0] wb_dat_r;
    wire  [4:0]  cpu_reg_wr;
    wire  [15:0] cpu_reg_wdata, mem_addr;
    wire  [7:0]  mem_wdata;
    wire  [7:0]  mem_rdata = mem_addr[7:0] ^ 8'h5a;
    int          err_total = 0, checks_done = 0, lo, n_halt = 0, n_run = 0, n_step = 0, n_force = 0, n_tag = 0;
    logic [7:0]  rc [5] = '{8'h68, 8'h69, 8'h6b, 8'h6f, 8'h6c};
    int          rw [5] = '{8, 8, 16, 16, 16};
    logic [15:0] re [5] = '{16'h003c, 16'h00c5, 16'h8123, 16'h00ff, 16'h0202};
    initial forever #2 core_clk = ~core_clk;
    always @(posedge core_clk) begin
        n_halt += halt_req;
        n_run += resume_req;
        n_step += step_req;
        n_force += force_bkpt;
        n_tag += tag_bkpt;
        if (cpu_reg_wr != 5'h00) wr_seen <= cpu_reg_wr;
        if (cpu_reg_wr[3]) cpu_hx <= cpu_reg_wdata; // CPU keeps what debug writes to hx
    end
    debug_pod_model i_debug_pod_model (.core_clk, .pin_drive, .pin_oe_n, .pin_level);
    debug_wire_cmd_unit i_debug_wire_cmd_unit (.core_clk, .srst, .debug_wire_pin_level(pin_level),
        .debug_wire_pin_drive(pin_drive), .debug_wire_pin_oe_n(pin_oe_n), .wb_adr, .wb_dat_w, .wb_dat_r, .wb_sel,
        .wb_we, .wb_cyc, .wb_stb, .wb_ack, .cpu_halted, .cpu_acc(8'h3c), .cpu_flags(8'hc5), .cpu_pc(16'h8123),
        .cpu_hx, .cpu_sp(16'h00ff), .cpu_reg_wr, .cpu_reg_wdata, .halt_req, .resume_req, .step_req, .mem_req,
        .mem_we, .mem_addr, .mem_wdata, .mem_rdata, .cpu_addr, .cpu_access, .cpu_fetch, .force_bkpt, .tag_bkpt);
    task automatic chk(input string n, input [31:0] e, input [31:0] s);
        checks_done++;
        if (s !== e) begin
            err_total++;
            $display("ERROR %s exp %h got %h", n, e, s);
        end
    endtask
    task automatic hc(input [7:0] c, input int ni, input [23:0] di, input int dl, input int no);
        i_debug_pod_model.cmd(c, ni, di, dl, no, q);
    endtask
    task automatic wb(input logic w, input [3:0] a, input [31:0] d);
        @(posedge core_clk);
        {wb_cyc, wb_stb, wb_we, wb_adr, wb_dat_w, wb_sel} <= {2'b11, w, a, d, 4'hf};
        do @(posedge core_clk); while (wb_ack !== 1'b1);
        r = wb_dat_r;
        {wb_cyc, wb_stb} <= 2'b00;
    endtask
    task automatic pk(input [15:0] a, input logic f);
        @(posedge core_clk);
        {cpu_addr, cpu_access, cpu_fetch} <= {a, 1'b1, f};
        @(posedge core_clk);
        {cpu_access, cpu_fetch} <= 2'b00;
        repeat (2) @(posedge core_clk);
    endtask
    task automatic stop_test;
        $display("checks %0d errors %0d", checks_done, err_total);
        if (err_total == 0 && checks_done > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask
    // Traffic covers roughly 12k cycles; the watchdog fires at 75k
    initial begin
        #300000;
        err_total++;
        stop_test;
    end
    initial begin
        repeat (12) @(posedge core_clk);
        srst <= 1'b0;
        repeat (4) @(posedge core_clk);
        wb(0, 4'h0, 0); chk("ctrl", 0, r);
        wb(0, 4'hc, 0); chk("unmapped", 0, r);
        hc(8'hc4, 8, 24'hb0, 0, 0);
        hc(8'hd5, 0, 0, 16, 0);
        hc(8'he4, 0, 0, 0, 8); chk("ack on", 16'hb8, q);
        hc(8'hd6, 0, 0, 16, 0);
        hc(8'he4, 0, 0, 0, 8); chk("status", 16'hb0, q);
        hc(8'hc2, 16, 24'h1234, 0, 0);
        hc(8'he2, 0, 0, 0, 16); chk("match", 16'h1234, q);
        wb(0, 4'h4, 0); chk("wb match", 32'h1234, r);
        pk(16'h1235, 0); pk(16'h1234, 0); chk("forced", 1, n_force);
        wb(1, 4'h0, 32'ha0); pk(16'h1234, 0); pk(16'h1234, 1); chk("tagged", 2, n_tag + n_force);
        wb(1, 4'h0, 32'h80); pk(16'h1234, 1); chk("off", 1, n_tag);
        hc(8'h90, 0, 0, 16, 0); chk("halt", 1, n_halt);
        hc(8'hc4, 8, 24'h00, 0, 0);
        hc(8'h90, 0, 0, 16, 0); chk("no halt", 1, n_halt);
        hc(8'hc0, 24, 24'h43215e, 16, 0);
        chk("write", 25'h143215e, {mem_we, mem_addr, mem_wdata});
        hc(8'he1, 16, 24'h4000, 16, 16); chk("read", 16'h005a, q);
        hc(8'he8, 0, 0, 0, 16); chk("reread", 17'h0005a, {mem_we, q});
        hc(8'h48, 8, 24'h11, 16, 0); chk("running", 0, wr_seen);
        cpu_halted <= 1'b1;
        hc(8'h4b, 16, 24'h9abc, 16, 0); chk("pc load", 21'h49abc, {wr_seen, cpu_reg_wdata});
        hc(8'h70, 0, 0, 16, 8); chk("next", 24'h02015b, {mem_addr, q[7:0]});
        hc(8'h51, 8, 24'h77, 16, 8); chk("next wr", 32'h02027740, {mem_addr, mem_wdata, q[7:0]});
        for (int i = 0; i < 5; i++) begin
            hc(rc[i], 0, 0, 16, rw[i]); chk("cpu reg", re[i], q);
        end
        hc(8'h10, 0, 0, 16, 0);
        hc(8'h08, 0, 0, 16, 0);
        hc(8'h18, 0, 0, 16, 0); chk("run ctl", 6, {n_step[0], n_run[1:0]});
        i_debug_pod_model.sync(lo); chk("sync low", 128, lo);
        cpu_halted <= 1'b0;
        for (int i = 0; i < 4; i++) i_debug_pod_model.bitx(1'b1, b1);
        repeat (600) @(posedge core_clk);
        hc(8'he4, 0, 0, 0, 8); chk("timeout", 0, q);
        wb(0, 4'h8, 0); chk("wb state", 32'he4, r);
        stop_test;
    end
endmodule // debug_wire_cmd_unit_tb_top
